//--- bvpc_pkg.sv
// Package for the boot strap status and port clocking select register bank.
// Assumes one 25 MHz clock domain and a byte-addressed Avalon-MM register slave.
package bvpc_pkg;

   // ----------------------------------------
   // Bus geometry and register offsets
   // ----------------------------------------
   localparam int          BVPC_ADDR_W        = 4;
   localparam int          BVPC_DATA_W        = 32;
   localparam int          BVPC_BE_W          = 4;
   localparam int          BVPC_NUM_PORTS     = 16;
   localparam int          BVPC_FIELD_W       = 2;
   localparam logic [3:0]  BVPC_STATUS_OFS    = 4'h4;
   localparam logic [3:0]  BVPC_PORT_CLK_OFS  = 4'h8;
   localparam logic [31:0] BVPC_ZERO_WORD     = 32'h00000000;

   // ----------------------------------------
   // Boot strap status field positions
   // ----------------------------------------
   localparam int          BVPC_SWITCH_OPERATING_STRAP_LSB    = 0;
   localparam int          BVPC_FREQ_BIT      = 4;
   localparam int          BVPC_MADDR_LSB     = 7;
   localparam int          BVPC_MSLOW_BIT     = 11;
   localparam int          BVPC_SADDR_LSB     = 12;
   localparam int          BVPC_HALT_BIT      = 16;
   localparam int          BVPC_CLKS_LSB      = 21;
   localparam int          BVPC_MERGE_LSB     = 24;
   localparam logic [31:0] BVPC_STATUS_RSVD   = 32'h001E0060;

   // ----------------------------------------
   // Per-port clocking field encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      BVPC_CLK_GLOBAL = 2'h0,
      BVPC_CLK_LOCAL  = 2'h1,
      BVPC_CLK_RSVD   = 2'h2
   } bvpc_clk_mode_t;

   // ----------------------------------------
   // Bus slave states
   // ----------------------------------------
   typedef enum logic {
      BVPC_IDLE   = 1'b0,
      BVPC_ANSWER = 1'b1
   } bvpc_bus_state_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] merge_ports;                 // Pair 0/1 in bit 0
      logic [2:0] clocking_scheme_strap;
      logic       halt_after_reset_strap;
      logic [3:0] slave_mgmt_bus_addr_strap;
      logic       master_mgmt_bus_slow_strap;
      logic [3:0] master_mgmt_bus_addr_strap;
      logic       global_clock_freq_select;
      logic [3:0] switch_operating_strap;
   } bvpc_straps_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } bvpc_avl_req_t;

endpackage : bvpc_pkg

//--- bvpc_regs.sv
// Boot strap status and per-port clocking select registers with Avalon-MM slave.
// Assumes reset is the fundamental reset; soft_reset covers every lighter reset.
`timescale 1ns/10ps
module bvpc_regs
#(
   parameter int NUM_PORTS = 16
)
(
   // Clock and resets
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          soft_reset,
   // Strap pins
   input  wire bvpc_pkg::bvpc_straps_t        straps_in,
   // Avalon-MM slave
   input  wire bvpc_pkg::bvpc_avl_req_t       avl_req,
   output logic [bvpc_pkg::BVPC_DATA_W-1:0]   readdata,
   output logic                               waitrequest,
   // Port clocking controls and captured straps
   output logic [NUM_PORTS-1:0]               port_local_clk,
   output bvpc_pkg::bvpc_straps_t             boot_straps
);
   import bvpc_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // Sixteen 2-bit fields exactly fill the 32-bit register
   if (NUM_PORTS * BVPC_FIELD_W != BVPC_DATA_W)
   begin : g_bad_ports
      $error("bvpc_regs: NUM_PORTS must fill the 32-bit clocking register");
   end

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Packs the sampled straps into the status word, reserved bits zero
   function automatic logic [BVPC_DATA_W-1:0] bvpc_status_word(input bvpc_straps_t s);
      logic [BVPC_DATA_W-1:0] w;
      w = BVPC_ZERO_WORD;
      w[BVPC_SWITCH_OPERATING_STRAP_LSB +: 4] = s.switch_operating_strap;
      w[BVPC_FREQ_BIT]        = s.global_clock_freq_select;
      w[BVPC_MADDR_LSB +: 4]  = s.master_mgmt_bus_addr_strap;
      w[BVPC_MSLOW_BIT]       = s.master_mgmt_bus_slow_strap;
      w[BVPC_SADDR_LSB +: 4]  = s.slave_mgmt_bus_addr_strap;
      w[BVPC_HALT_BIT]        = s.halt_after_reset_strap;
      w[BVPC_CLKS_LSB +: 3]   = s.clocking_scheme_strap;
      w[BVPC_MERGE_LSB +: 8]  = s.merge_ports;
      return w & ~BVPC_STATUS_RSVD;
   endfunction

   // Start-up clocking of one port from the scheme strap; bit 0 picks local
   function automatic logic [BVPC_FIELD_W-1:0] bvpc_clk_init(input logic [2:0] scheme);
      return scheme[0] ? BVPC_CLK_LOCAL : BVPC_CLK_GLOBAL;
   endfunction

   // Merges one write into the field word; reserved codes leave a field as it was
   function automatic logic [BVPC_DATA_W-1:0] bvpc_field_write(
      input logic [BVPC_DATA_W-1:0] old_w,
      input logic [BVPC_DATA_W-1:0] wdata,
      input logic [BVPC_BE_W-1:0]   be
   );
      logic [BVPC_DATA_W-1:0]  w;
      logic [BVPC_FIELD_W-1:0] f;
      w = old_w;
      for (int i = 0; i < BVPC_DATA_W / BVPC_FIELD_W; i++)
      begin
         f = wdata[i*BVPC_FIELD_W +: BVPC_FIELD_W];
         if (be[(i*BVPC_FIELD_W)/8] && (f == BVPC_CLK_GLOBAL || f == BVPC_CLK_LOCAL))
         begin
            w[i*BVPC_FIELD_W +: BVPC_FIELD_W] = f;
         end
      end
      return w;
   endfunction

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   bvpc_straps_t           straps_q;
   logic [BVPC_DATA_W-1:0] fields_q;
   logic [BVPC_DATA_W-1:0] fields_d;
   bvpc_bus_state_t        state_q;
   logic [BVPC_DATA_W-1:0] readdata_q;
   logic [NUM_PORTS-1:0]   local_q;
   logic                   take_req;
   logic                   wr_done;
   logic                   wait_q;

   // Straps follow the pins while reset is held and freeze at its release
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         straps_q <= straps_in;
      end
   end

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------
   // A request is taken while waitrequest is high; the answer follows one edge later
   assign take_req = (avl_req.read || avl_req.write) && (state_q == BVPC_IDLE);
   assign wr_done  = avl_req.write && (state_q == BVPC_ANSWER) &&
                     (avl_req.address == BVPC_PORT_CLK_OFS);

   // Two-state slave; a lighter reset also clears it
   always_ff @(posedge clk)
   begin
      if (reset || soft_reset)
      begin
         state_q <= BVPC_IDLE;
      end
      else
      begin
         case (state_q)
            BVPC_IDLE:   state_q <= take_req ? BVPC_ANSWER : BVPC_IDLE;
            BVPC_ANSWER: state_q <= BVPC_IDLE;
            default:     state_q <= BVPC_IDLE;
         endcase
      end
   end

   // Waitrequest kept in its own flop so the pin never sees decode glitches
   always_ff @(posedge clk)
   begin
      if (reset || soft_reset)
      begin
         wait_q <= 1'h1;
      end
      else
      begin
         wait_q <= !take_req;                                    // Low only in the answer cycle
      end
   end

   // Read data sampled when the request is taken; unmapped reads return zero
   always_ff @(posedge clk)
   begin
      if (reset || soft_reset)
      begin
         readdata_q <= BVPC_ZERO_WORD;
      end
      else if (take_req && avl_req.read)
      begin
         case (avl_req.address)
            BVPC_STATUS_OFS:   readdata_q <= bvpc_status_word(straps_q);
            BVPC_PORT_CLK_OFS: readdata_q <= fields_q;
            default:           readdata_q <= BVPC_ZERO_WORD;
         endcase
      end
   end

   // ----------------------------------------
   // Port clocking fields
   // ----------------------------------------
   // Write lands on the edge that sees waitrequest low, matching the master
   always_comb
   begin
      fields_d = fields_q;
      if (wr_done)
      begin
         fields_d = bvpc_field_write(fields_q, avl_req.writedata, avl_req.byteenable);
      end
   end

   // Only fundamental reset reloads; soft_reset is deliberately ignored here
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fields_q <= {NUM_PORTS{bvpc_clk_init(straps_in.clocking_scheme_strap)}};
      end
      else
      begin
         fields_q <= fields_d;
      end
   end

   // Per-port local clocking select, one flop per port
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         local_q <= '0;
      end
      else
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            local_q[p] <= (fields_q[p*BVPC_FIELD_W +: BVPC_FIELD_W] == BVPC_CLK_LOCAL);
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign readdata       = readdata_q;
   assign waitrequest    = wait_q;                   // High in reset and idle
   assign port_local_clk = local_q;
   assign boot_straps    = straps_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Helper decode of the current full-lane write and its expected fields
   logic                   chk_wr_ok;
   logic [BVPC_DATA_W-1:0] chk_expect;
   assign chk_wr_ok  = wr_done && (avl_req.byteenable == 4'hF);
   assign chk_expect = bvpc_field_write(fields_q, avl_req.writedata, 4'hF);

   sequence s_read_status;
      avl_req.read && (avl_req.address == BVPC_STATUS_OFS) && waitrequest;
   endsequence

   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence

   sequence s_read_fields;
      avl_req.read && (avl_req.address == BVPC_PORT_CLK_OFS) && waitrequest;
   endsequence

   // Helper flag: some field holds a reserved code (upper bit set)
   logic chk_any_rsvd;
   always_comb
   begin
      chk_any_rsvd = 1'h0;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         if (fields_q[p*BVPC_FIELD_W + 1])
         begin
            chk_any_rsvd = 1'h1;
         end
      end
   end

   chk_status_value: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_status |=> (readdata == bvpc_status_word(straps_q)))
      else $error("status read does not match sampled straps");

   chk_status_rsvd: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_status |=> ((readdata & BVPC_STATUS_RSVD) == BVPC_ZERO_WORD))
      else $error("reserved status bits not zero");

   chk_mode_bits: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_status |=> (readdata[3:0] == straps_q.switch_operating_strap) &&
                        (readdata[4] == straps_q.global_clock_freq_select))
      else $error("switch mode or frequency bits wrong");

   chk_bus_bits: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_status |=> (readdata[10:7] == straps_q.master_mgmt_bus_addr_strap) &&
                        (readdata[15:12] == straps_q.slave_mgmt_bus_addr_strap) &&
                        (readdata[11] == straps_q.master_mgmt_bus_slow_strap))
      else $error("management bus strap bits wrong");

   chk_merge_bits: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_status |=> (readdata[31:24] == straps_q.merge_ports) &&
                        (readdata[23:21] == straps_q.clocking_scheme_strap) &&
                        (readdata[16] == straps_q.halt_after_reset_strap))
      else $error("merge, scheme or halt bits wrong");

   chk_strap_frozen: assert property (@(posedge clk) disable iff (reset)
      ##1 $stable(straps_q))
      else $error("straps changed outside fundamental reset");

   chk_answer_once: assert property (@(posedge clk) disable iff (reset || soft_reset)
      take_req |=> s_answer)
      else $error("waitrequest did not drop for exactly one cycle");

   chk_field_init: assert property (@(posedge clk)
      reset |=> (fields_q == {NUM_PORTS{bvpc_clk_init($past(straps_in.clocking_scheme_strap))}}))
      else $error("fields not loaded from clocking straps");

   chk_field_write: assert property (@(posedge clk) disable iff (reset)
      chk_wr_ok |=> (fields_q == $past(chk_expect)))
      else $error("full write to clocking fields not applied");

   chk_rsvd_code: assert property (@(posedge clk) disable iff (reset)
      wr_done && (avl_req.writedata[1:0] == BVPC_CLK_RSVD) |=> $stable(fields_q[1:0]))
      else $error("reserved clocking code was stored");

   chk_local_follow: assert property (@(posedge clk) disable iff (reset)
      $past(!reset) |-> (port_local_clk[0] == ($past(fields_q[1:0]) == BVPC_CLK_LOCAL)))
      else $error("port 0 clocking output does not follow its field");

   chk_soft_keep: assert property (@(posedge clk) disable iff (reset)
      soft_reset && !wr_done |=> $stable(fields_q))
      else $error("lighter reset disturbed clocking fields");

   chk_wait_reset: assert property (@(posedge clk)
      (reset || soft_reset) |=> waitrequest)
      else $error("waitrequest low after reset");

   chk_wait_single: assert property (@(posedge clk) disable iff (reset || soft_reset)
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   chk_readdata_hold: assert property (@(posedge clk) disable iff (reset || soft_reset)
      !reset && !soft_reset && !(take_req && avl_req.read) |=> $stable(readdata))
      else $error("read data changed without a read");

   chk_ro_write: assert property (@(posedge clk) disable iff (reset)
      avl_req.write && !waitrequest && (avl_req.address != BVPC_PORT_CLK_OFS) |=> $stable(fields_q))
      else $error("write outside the clocking register changed fields");

   chk_lane_keep: assert property (@(posedge clk) disable iff (reset)
      wr_done && !avl_req.byteenable[0] |=> $stable(fields_q[7:0]))
      else $error("disabled byte lane was written");

   chk_strap_capture: assert property (@(posedge clk)
      reset |=> (straps_q == $past(straps_in)))
      else $error("straps not captured during fundamental reset");

   chk_local_reset: assert property (@(posedge clk)
      reset |=> (port_local_clk == '0))
      else $error("port clocking outputs not cleared by reset");

   chk_field_legal: assert property (@(posedge clk) disable iff (reset)
      !chk_any_rsvd)
      else $error("a clocking field holds a reserved code");

   chk_read_fields: assert property (@(posedge clk) disable iff (reset || soft_reset)
      s_read_fields |=> (readdata == $past(fields_q)))
      else $error("clocking register read does not match fields");

   chk_unmapped_zero: assert property (@(posedge clk) disable iff (reset || soft_reset)
      avl_req.read && waitrequest && (avl_req.address != BVPC_STATUS_OFS) &&
      (avl_req.address != BVPC_PORT_CLK_OFS) |=> (readdata == BVPC_ZERO_WORD))
      else $error("unmapped read did not return zero");

endmodule // bvpc_regs

//--- tb_top.sv
// Self-checking bench for the boot strap status and port clocking select bank.
// Assumes bvpc_pkg and bvpc_regs are compiled first; the bench alone drives every port.
`timescale 1ns/10ps
module tb_top;
   import bvpc_pkg::*;

   // ----------------------------------------
   // Signals and counters
   // ----------------------------------------
   logic                   clk;
   logic                   reset;
   logic                   soft_reset;
   bvpc_straps_t           straps_in;
   bvpc_avl_req_t          avl_req;
   logic [BVPC_DATA_W-1:0] readdata;
   logic                   waitrequest;
   logic [15:0]            port_local_clk;
   bvpc_straps_t           boot_straps;
   logic [31:0]            fld;
   logic [31:0]            rd;
   int                     err_count;
   int                     n_tests;
   int                     cycles;
   // Strap set A: scheme bit0 set, so fields start local
   localparam bvpc_straps_t SA = '{8'hA5, 3'h5, 1'h1, 4'hC, 1'h1, 4'h3, 1'h1, 4'h6};
   localparam bvpc_straps_t SB = ~SA;          // Inverse of SA: fields start global

   // ----------------------------------------
   // Design under test
   // ----------------------------------------
   bvpc_regs #(.NUM_PORTS(16)) u_bvpc_regs
   (
      .clk            (clk),
      .reset          (reset),
      .soft_reset     (soft_reset),
      .straps_in      (straps_in),
      .avl_req        (avl_req),
      .readdata       (readdata),
      .waitrequest    (waitrequest),
      .port_local_clk (port_local_clk),
      .boot_straps    (boot_straps)
   );

   // Clock, 40 ns period
   always #20 clk = ~clk;

   // Hang guard; a full run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_count = err_count + 1;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   // Status word built field by field from the strap struct
   function automatic logic [31:0] stat_of(bvpc_straps_t s);
      return {s.merge_ports, s.clocking_scheme_strap, 4'h0, s.halt_after_reset_strap,
              s.slave_mgmt_bus_addr_strap, s.master_mgmt_bus_slow_strap,
              s.master_mgmt_bus_addr_strap, 2'h0, s.global_clock_freq_select, s.switch_operating_strap};
   endfunction

   // Field update: enabled lane, codes 2 and 3 leave the old value
   function automatic logic [31:0] apply(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int p = 0; p < 16; p++)
         if (be[p/4] && wd[2*p+1] == 1'b0)
            r[2*p +: 2] = wd[2*p +: 2];
      return r;
   endfunction

   // Local clocking flag per port
   function automatic logic [15:0] local_of(logic [31:0] f);
      logic [15:0] m;
      for (int p = 0; p < 16; p++)
         m[p] = (f[2*p +: 2] == 2'h1);
      return m;
   endfunction

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Request held until the edge that samples waitrequest low
   task automatic bus_xfer(logic wr, logic [3:0] a, logic [3:0] be, logic [31:0] wd, output logic [31:0] data);
      @(posedge clk);
      avl_req.read <= ~wr;
      avl_req.write <= wr;
      avl_req.address <= a;
      avl_req.byteenable <= be;
      avl_req.writedata <= wd;
      do @(posedge clk); while (waitrequest !== 1'b0);
      data = readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask

   task automatic bus_rd(logic [3:0] a, output logic [31:0] data);
      bus_xfer(1'b0, a, 4'hF, 32'h0, data);
   endtask

   task automatic bus_wr(logic [3:0] a, logic [3:0] be, logic [31:0] wd);
      logic [31:0] dummy;
      bus_xfer(1'b1, a, be, wd, dummy);
      if (a == BVPC_PORT_CLK_OFS)
         fld = apply(fld, wd, be);
   endtask

   // Fundamental reset for six cycles with the given straps on the pins
   task automatic do_reset(bvpc_straps_t s);
      straps_in <= s;
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      fld = s.clocking_scheme_strap[0] ? 32'h55555555 : 32'h0;
   endtask

   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      soft_reset = 1'b0;
      straps_in = SA;
      avl_req = '0;
      err_count = 0;
      n_tests = 0;
      cycles = 0;
      do_reset(SA);
      straps_in <= SB;                                        // Pins move; capture must stay
      bus_rd(BVPC_STATUS_OFS, rd);
      check("status", rd, stat_of(SA));
      check("boot_straps", {6'h0, boot_straps}, {6'h0, SA});
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      check("local", {16'h0, port_local_clk}, {16'h0, local_of(fld)});
      // Mixed codes, reserved ones ignored, then a partial lane write
      bus_wr(BVPC_PORT_CLK_OFS, 4'hF, 32'hE4E41B1B);
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      repeat (2) @(posedge clk);
      check("local", {16'h0, port_local_clk}, {16'h0, local_of(fld)});
      bus_wr(BVPC_PORT_CLK_OFS, 4'h6, 32'h12344411);
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      // Status is read-only; unmapped places read zero
      bus_wr(BVPC_STATUS_OFS, 4'hF, 32'hFFFFFFFF);
      bus_rd(BVPC_STATUS_OFS, rd);
      check("status", rd, stat_of(SA));
      bus_wr(4'hC, 4'hF, 32'hFFFFFFFF);
      bus_rd(4'hC, rd);
      check("unmapped", rd, BVPC_ZERO_WORD);
      bus_rd(4'h0, rd);
      check("unmapped", rd, BVPC_ZERO_WORD);
      // Lighter reset keeps written fields
      @(posedge clk);
      soft_reset <= 1'b1;
      repeat (2) @(posedge clk);
      soft_reset <= 1'b0;
      @(posedge clk);
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      bus_rd(BVPC_STATUS_OFS, rd);
      check("status", rd, stat_of(SA));
      // Fundamental reset reloads captured straps and fields from the new straps
      do_reset(SB);
      bus_rd(BVPC_STATUS_OFS, rd);
      check("status", rd, stat_of(SB));
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      bus_wr(BVPC_PORT_CLK_OFS, 4'hF, 32'h55555555);
      bus_rd(BVPC_PORT_CLK_OFS, rd);
      check("fields", rd, fld);
      repeat (2) @(posedge clk);
      check("local", {16'h0, port_local_clk}, 32'h0000FFFF);
      end_of_test();
   end

endmodule // tb_top
